// ===== verilog/dual_adc_output_control.sv
// output control of a dual 12-bit converter: power, bus modes, coding, test
// assumes sample clock, converter codes and pins are asynchronous to clk_i
//
// Operation
// - power-down pin high or power register selects power-down
// - powered down: all data and clock drivers released
// - power-down pin low returns to normal operation
// - power register offers full power-down and standby keeping reference on
// - after reset: CMOS, each channel on its own bus
// - interleaved mode puts both channels onto bus A
// - output mode bit 5 enables interleaving for both channels
// - strap mode: format pin low offset binary, high twos complement
// - register mode offers offset binary, twos complement and Gray
// - with three-state enabled, output-enable-low pin high releases outputs
// - each channel's port disable releases its data and clock
// - results reach outputs sixteen sample clocks later, at rising edge
// - CMOS: two data clocks, data valid on rising unless inverted
// - LVDS: clock aligned with data plus delay; A rising, B falling
// - offset binary midscale 0x800, twos flips MSB, saturate with over-range
// - selected test mode replaces converter results before formatting
// - test register bits 4 and 5 reset the sequence generators
// - test patterns ignore input, advance only on sample clock edges
// - strap mode: format and stabilizer pins sampled once after reset
`default_nettype none
module dual_adc_output_control
  import adc_out_pkg::*;
#(
  parameter int LAT = LATENCY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        sample_clk_i,
  input  wire logic [13:0] conv_a_i,
  input  wire logic [13:0] conv_b_i,
  input  wire logic        power_down_pin_i,
  input  wire logic        output_enable_low_pin_i,
  input  wire logic        serial_clock_format_pin_i,
  input  wire logic        serial_data_stabilizer_pin_i,
  input  wire logic        serial_select_low_i,
  input  wire logic [9:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output chan_out_s        chan_a_o,
  output chan_out_s        chan_b_o,
  output logic             powered_down_o,
  output logic             reference_on_o,
  output logic             stabilizer_en_o
);
  // --------------------------------------------------------------------
  // parameters and state
  // --------------------------------------------------------------------
  localparam int IW = $clog2(LAT);

  if (LAT < 2 || LAT > 64) begin : g_bad_lat
    $error("LAT must lie between 2 and 64");
  end

  typedef struct packed {
    logic [SYNC_W-1:0]      s1;
    logic [SYNC_W-1:0]      s2;
    logic                   sclk_d;
    logic [6:0]             sclk_hist;
    logic [1:0]             strap_cnt;
    logic                   strap_fmt;
    logic                   strap_stab;
    logic [1:0]             chan_idx;
    logic [1:0]             pmode;
    logic [7:0]             test;
    logic [1:0]             fmt;
    logic                   inter;
    logic                   lvds;
    logic [1:0]             port_dis;
    logic                   inv;
    logic [2:0]             dco_dly;
    logic                   ts_en;
    pwr_e                   pwr;
    logic                   pdn;
    logic                   ref_on;
    logic [1:0][15:0]       lfsr;
    logic                   chk;
    logic [LAT-1:0][25:0]   pipe;
    logic [IW-1:0]          idx;
    logic [25:0]            cur;
    logic [7:0]             rdata;
    chan_out_s              cha;
    chan_out_s              chb;
  } st_s;

  st_s st_reg;
  st_s st_next;

  // --------------------------------------------------------------------
  // data path helpers
  // --------------------------------------------------------------------
  function automatic logic [12:0] front(input logic [13:0] v,
                                       input logic [3:0]  tm,
                                       input logic [15:0] pn,
                                       input logic        chk);
    logic [12:0] w;
    w = {1'b0, MIDSCALE};
    case (tm)
      TM_OFF: begin
        if ($signed(v) > SAT_HI) begin
          w = {1'b1, FS_POS};
        end else if ($signed(v) < SAT_LO) begin
          w = {1'b1, FS_NEG};
        end else begin
          w = {1'b0, v[11:0] ^ MIDSCALE};
        end
      end
      TM_MID: w = {1'b0, MIDSCALE};
      TM_POS: w = {1'b0, FS_POS};
      TM_NEG: w = {1'b0, FS_NEG};
      TM_CHK: w = {1'b0, chk ? CHECKER : ~CHECKER};
      TM_PN:  w = {1'b0, pn[11:0]};
      TM_TOG: w = {1'b0, chk ? FS_POS : FS_NEG};
      default: w = {1'b0, MIDSCALE};
    endcase
    return w;
  endfunction

  function automatic logic [11:0] fmtf(input logic [11:0] ob, input logic [1:0] sel);
    logic [11:0] r;
    r = ob;
    case (sel)
      FMT_TWOS: r = {~ob[11], ob[10:0]};
      FMT_GRAY: r = ob ^ (ob >> 1);
      default:  r = ob;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  logic        rise;
  logic        fall;
  logic        pin_mode;
  logic [1:0]  fmt_sel;
  logic        pd_req;
  logic        stby_req;
  pwr_e        pwr_n;
  logic        drive;
  logic        single;
  logic        lvl;
  logic [7:0]  hist;
  logic [12:0] wa;
  logic [12:0] wb;
  logic [25:0] out;

  always_comb begin
    st_next = st_reg;
    rise = 1'b0;
    fall = 1'b0;
    pin_mode = 1'b0;
    fmt_sel = FMT_OB;
    pd_req = 1'b0;
    stby_req = 1'b0;
    pwr_n = PWR_ON;
    drive = 1'b0;
    single = 1'b1;
    lvl = 1'b0;
    hist = 8'h00;
    wa = 13'h0000;
    wb = 13'h0000;
    out = 26'h0000000;

    // first stage feeds only the second
    st_next.s1 = {conv_b_i, conv_a_i, serial_select_low_i, serial_data_stabilizer_pin_i,
                  serial_clock_format_pin_i, output_enable_low_pin_i, power_down_pin_i,
                  sample_clk_i};
    st_next.s2 = st_reg.s1;
    st_next.sclk_d = st_reg.s2[SY_SCLK];
    st_next.sclk_hist = {st_reg.sclk_hist[5:0], st_reg.s2[SY_SCLK]};
    rise = st_reg.s2[SY_SCLK] & ~st_reg.sclk_d;
    fall = ~st_reg.s2[SY_SCLK] & st_reg.sclk_d;
    pin_mode = st_reg.s2[SY_SSL];

    // straps caught once the synchroniser holds real pin levels
    if (st_reg.strap_cnt != 2'h3) begin
      st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
    end
    if (st_reg.strap_cnt == STRAP_AT) begin
      st_next.strap_fmt = st_reg.s2[SY_FMT];
      st_next.strap_stab = st_reg.s2[SY_STAB];
    end

    // register writes; the serial port ignores writes in strap mode
    if (reg_wr_i && !pin_mode) begin
      case (reg_addr_i)
        REG_CHAN_IDX:  st_next.chan_idx = reg_wdata_i[1:0];
        REG_POWER:     st_next.pmode = reg_wdata_i[1:0];
        REG_TEST:      st_next.test = reg_wdata_i;
        REG_OUT_MODE: begin
          st_next.fmt = reg_wdata_i[1:0];
          st_next.inter = reg_wdata_i[OM_INTERL_BIT];
          st_next.lvds = reg_wdata_i[OM_LVDS_BIT];
          for (int c = 0; c < 2; c++) begin
            if (st_reg.chan_idx[c]) begin
              st_next.port_dis[c] = reg_wdata_i[OM_PORT_DIS_BIT];
            end
          end
        end
        REG_PHASE:     st_next.inv = reg_wdata_i[PH_INVERT_BIT];
        REG_DCO_DELAY: st_next.dco_dly = reg_wdata_i[2:0];
        REG_OUT_CTRL:  st_next.ts_en = reg_wdata_i[OC_TRISTATE_BIT];
        default: ;
      endcase
    end

    // read data stands only in the cycle after the strobe
    st_next.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CHAN_IDX:  st_next.rdata = {6'h00, st_reg.chan_idx};
        REG_POWER:     st_next.rdata = {6'h00, st_reg.pmode};
        REG_TEST:      st_next.rdata = st_reg.test;
        REG_OUT_MODE:  st_next.rdata = {st_reg.lvds, 1'b0, st_reg.inter,
                                        st_reg.chan_idx[0] ? st_reg.port_dis[0]
                                                           : st_reg.port_dis[1],
                                        2'h0, st_reg.fmt};
        REG_PHASE:     st_next.rdata = {st_reg.inv, 7'h00};
        REG_DCO_DELAY: st_next.rdata = {5'h00, st_reg.dco_dly};
        REG_OUT_CTRL:  st_next.rdata = {st_reg.ts_en, 7'h00};
        REG_STATUS:    st_next.rdata = {3'h0, st_reg.strap_stab, st_reg.strap_fmt,
                                        pin_mode, st_reg.ref_on, st_reg.pdn};
        default:       st_next.rdata = 8'h00;
      endcase
    end

    // power: the pin always wins and forces full power-down
    pd_req = st_reg.s2[SY_PD] || (!pin_mode && st_reg.pmode == PM_OFF);
    stby_req = !pin_mode && st_reg.pmode == PM_STBY;
    if (pd_req) begin
      pwr_n = PWR_OFF;
    end else if (stby_req) begin
      pwr_n = PWR_STBY;
    end else begin
      pwr_n = PWR_ON;
    end
    st_next.pwr = pwr_n;
    unique case (pwr_n)
      PWR_ON: begin
        st_next.pdn = 1'b0;
        st_next.ref_on = 1'b1;
      end
      PWR_STBY: begin
        st_next.pdn = 1'b1;
        st_next.ref_on = 1'b1;
      end
      PWR_OFF: begin
        st_next.pdn = 1'b1;
        st_next.ref_on = 1'b0;
      end
      default: begin
        st_next.pdn = 1'b1;
        st_next.ref_on = 1'b0;
      end
    endcase

    // coding and test patterns; all but the PN reset move only with the sample clock
    fmt_sel = pin_mode ? (st_reg.strap_fmt ? FMT_TWOS : FMT_OB) : st_reg.fmt;
    if (rise) begin
      for (int c = 0; c < 2; c++) begin
        st_next.lfsr[c] = {st_reg.lfsr[c][14:0], st_reg.lfsr[c][15] ^ st_reg.lfsr[c][13]
                           ^ st_reg.lfsr[c][12] ^ st_reg.lfsr[c][10]};
      end
      st_next.chk = ~st_reg.chk;
      wa = front(st_reg.s2[SY_CA +: 14], st_reg.test[3:0], st_reg.lfsr[0], st_reg.chk);
      wb = front(st_reg.s2[SY_CB +: 14], st_reg.test[3:0], st_reg.lfsr[1], st_reg.chk);
      st_next.pipe[st_reg.idx] = {wb[12], fmtf(wb[11:0], fmt_sel),
                                  wa[12], fmtf(wa[11:0], fmt_sel)};
      out = st_reg.pipe[st_reg.idx];
      st_next.cur = out;
      st_next.idx = (st_reg.idx == IW'(LAT - 1)) ? '0 : st_reg.idx + IW'(1);
    end
    if (st_reg.test[TM_PN_RST_A_BIT]) begin
      st_next.lfsr[0] = PN_SEED;
    end
    if (st_reg.test[TM_PN_RST_B_BIT]) begin
      st_next.lfsr[1] = PN_SEED;
    end

    // output buses
    single = !(st_reg.inter || st_reg.lvds);
    if (rise) begin
      st_next.cha.data = out[11:0];
      st_next.cha.ovr = out[12];
      if (single) begin
        st_next.chb.data = out[24:13];
        st_next.chb.ovr = out[25];
      end
    end
    if (fall && !single) begin
      st_next.cha.data = st_reg.cur[24:13];
      st_next.cha.ovr = st_reg.cur[25];
    end

    // data clocks: CMOS rises mid-sample, LVDS follows data edges plus delay
    hist = {st_reg.sclk_hist, st_reg.s2[SY_SCLK]};
    lvl = st_reg.lvds ? hist[st_reg.dco_dly] : ~st_reg.s2[SY_SCLK];
    st_next.cha.data_clock_output = lvl ^ st_reg.inv;
    st_next.chb.data_clock_output = lvl ^ st_reg.inv;

    // drivers; strap mode always lets the pin three-state
    drive = pwr_n == PWR_ON;
    if ((st_reg.ts_en || pin_mode) && st_reg.s2[SY_OEB]) begin
      drive = 1'b0;
    end
    st_next.cha.data_oe = drive && !st_reg.port_dis[0];
    st_next.cha.dco_oe = drive && !st_reg.port_dis[0];
    st_next.chb.data_oe = drive && !st_reg.port_dis[1];
    st_next.chb.dco_oe = drive && !st_reg.port_dis[1];
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.chan_idx <= CHAN_IDX_RST;
      st_reg.pwr <= PWR_ON;
      st_reg.ref_on <= 1'b1;
      st_reg.lfsr <= {PN_SEED, PN_SEED};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign chan_a_o = st_reg.cha;
  assign chan_b_o = st_reg.chb;
  assign powered_down_o = st_reg.pdn;
  assign reference_on_o = st_reg.ref_on;
  assign stabilizer_en_o = st_reg.strap_stab;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic [12:0] shadow;
  logic        shadow_ok;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shadow <= 13'h0000;
      shadow_ok <= 1'b0;
    end else if (rise && st_reg.idx == '0) begin
      shadow <= st_next.pipe[0][12:0];
      shadow_ok <= 1'b1;
    end
  end

  sequence s_rise;
    rise;
  endsequence
  sequence s_idle_pin;
    !st_reg.s2[SY_PD] && !pin_mode && st_reg.pmode == PM_ON;
  endsequence

  property p_pd_pin;
    st_reg.s2[SY_PD] |=> st_reg.pdn && !st_reg.ref_on;
  endproperty
  a_pd_pin: assert property (p_pd_pin) else $error("pin did not power down");

  property p_pd_hiz;
    st_reg.pdn |-> !chan_a_o.data_oe && !chan_b_o.dco_oe;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("driver on while down");

  property p_wake;
    s_idle_pin ##1 s_idle_pin |-> !st_reg.pdn;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after pin low");

  property p_stby;
    !st_reg.s2[SY_PD] && !pin_mode && st_reg.pmode == PM_STBY |=> st_reg.pdn && st_reg.ref_on;
  endproperty
  a_stby: assert property (p_stby) else $error("standby lost reference");

  property p_latency;
    s_rise and st_reg.idx == '0 and shadow_ok |=> {chan_a_o.ovr, chan_a_o.data} == $past(shadow);
  endproperty
  a_latency: assert property (p_latency) else $error("pipeline latency wrong");

  property p_sat;
    s_rise and st_reg.test[3:0] == TM_OFF and $signed(st_reg.s2[SY_CA +: 14]) > SAT_HI
      |=> st_reg.pipe[$past(st_reg.idx)][12] == 1'b1;
  endproperty
  a_sat: assert property (p_sat) else $error("over-range not flagged");

  property p_tristate;
    st_reg.ts_en && st_reg.s2[SY_OEB] |=> !chan_a_o.dco_oe && !chan_b_o.data_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pin did not release bus");

  property p_test_mid;
    s_rise and st_reg.test[3:0] == TM_MID and fmt_sel == FMT_OB
      |=> st_reg.pipe[$past(st_reg.idx)][11:0] == MIDSCALE;
  endproperty
  a_test_mid: assert property (p_test_mid) else $error("test pattern not injected");

  property p_pn_rst;
    st_reg.test[TM_PN_RST_A_BIT] |=> st_reg.lfsr[0] == PN_SEED;
  endproperty
  a_pn_rst: assert property (p_pn_rst) else $error("sequence not reset");

  property p_strap_fmt;
    pin_mode && st_reg.strap_fmt |-> fmt_sel == FMT_TWOS;
  endproperty
  a_strap_fmt: assert property (p_strap_fmt) else $error("strap format ignored");

endmodule
`default_nettype wire

// ===== pkg/adc_out_pkg.sv
// constants and carrier types for the dual converter output control block
// assumes one system clock; sample clock and pins arrive from outside it
`default_nettype none
package adc_out_pkg;
  // --------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------
  localparam logic [9:0] REG_CHAN_IDX  = 10'h005;
  localparam logic [9:0] REG_POWER     = 10'h008;
  localparam logic [9:0] REG_TEST      = 10'h00D;
  localparam logic [9:0] REG_OUT_MODE  = 10'h014;
  localparam logic [9:0] REG_PHASE     = 10'h016;
  localparam logic [9:0] REG_DCO_DELAY = 10'h017;
  localparam logic [9:0] REG_STATUS    = 10'h01F;
  localparam logic [9:0] REG_OUT_CTRL  = 10'h101;
  // --------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------
  localparam int OM_PORT_DIS_BIT = 4;
  localparam int OM_INTERL_BIT   = 5;
  localparam int OM_LVDS_BIT     = 7;
  localparam int OC_TRISTATE_BIT = 7;
  localparam int PH_INVERT_BIT   = 7;
  localparam int TM_PN_RST_A_BIT = 4;
  localparam int TM_PN_RST_B_BIT = 5;
  localparam logic [1:0] CHAN_IDX_RST = 2'h3;
  localparam logic [15:0] PN_SEED     = 16'hFFFF;
  localparam logic [11:0] MIDSCALE    = 12'h800;
  localparam logic [11:0] FS_POS      = 12'hFFF;
  localparam logic [11:0] FS_NEG      = 12'h000;
  localparam logic [11:0] CHECKER     = 12'h555;
  localparam logic signed [13:0] SAT_HI = 14'sh07FF;
  localparam logic signed [13:0] SAT_LO = 14'sh3800;
  localparam int LATENCY_CYC = 16;
  localparam logic [1:0] STRAP_AT = 2'h2;
  // synchroniser vector layout
  localparam int SY_SCLK = 0;
  localparam int SY_PD   = 1;
  localparam int SY_OEB  = 2;
  localparam int SY_FMT  = 3;
  localparam int SY_STAB = 4;
  localparam int SY_SSL  = 5;
  localparam int SY_CA   = 6;
  localparam int SY_CB   = 20;
  localparam int SYNC_W  = 34;
  // --------------------------------------------------------------------
  // enumerations and carriers
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {FMT_OB = 2'h0, FMT_TWOS = 2'h1, FMT_GRAY = 2'h2} fmt_e;
  typedef enum logic [1:0] {PM_ON = 2'h0, PM_OFF = 2'h1, PM_STBY = 2'h2} pmode_e;
  typedef enum logic [2:0] {PWR_ON = 3'h1, PWR_STBY = 3'h2, PWR_OFF = 3'h4} pwr_e;
  typedef enum logic [3:0] {
    TM_OFF = 4'h0, TM_MID = 4'h1, TM_POS = 4'h2, TM_NEG = 4'h3,
    TM_CHK = 4'h4, TM_PN = 4'h5, TM_TOG = 4'h7
  } tmode_e;
  typedef struct packed {
    logic        data_clock_output;
    logic        dco_oe;
    logic        ovr;
    logic [11:0] data;
    logic        data_oe;
  } chan_out_s;
endpackage
`default_nettype wire

// ===== testbench/capture_model.sv
// far-side capture register clocked by the data clock of one bus
// assumes the bus struct of the package; a released bus is not captured
`default_nettype none
module capture_model
  import adc_out_pkg::*;
(
  input  wire chan_out_s   bus_i,
  output logic      [11:0] cap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------
  // capture
  // --------------------------------------------------------------------
  // only a driven bus is taken, as a real register would see junk
  always @(posedge bus_i.data_clock_output) begin
    if (bus_i.data_oe === 1'b1) begin
      cap_o <= bus_i.data;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the dual converter output control block
// assumes a free 320 ns sample clock and the capture model on bus A
`default_nettype none
`define CHK(n, e, s) begin \
  compares++; \
  if ((s) !== (e)) begin \
    error_cnt++; \
    $display("ERROR %s exp %0h got %0h", n, e, s); \
  end \
end
module tb_top
  import adc_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // short pipe keeps the run brief; the waits for pipeline results derive from it
  localparam int LAT = 4;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        sample_clk_i = 1'b0;
  logic        sclk_en = 1'b1;
  logic [13:0] conv_a_i = 14'h0000;
  logic [13:0] conv_b_i = 14'h0000;
  logic        pd_pin = 1'b0;
  logic        oe_pin = 1'b0;
  logic        fmt_pin = 1'b0;
  logic        stab_pin = 1'b0;
  logic        sel_pin = 1'b0;
  logic [9:0]  reg_addr_i = 10'h000;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  chan_out_s   chan_a_o;
  chan_out_s   chan_b_o;
  logic        powered_down_o;
  logic        reference_on_o;
  logic        stabilizer_en_o;
  logic [11:0] cap;
  logic [7:0]  rv;
  logic [11:0] d;
  int          error_cnt = 0;
  int          compares = 0;
  int          vals[6] = '{0, 2047, -2048, 3000, -3000, 291};
  logic [11:0] tmx[3] = '{12'h800, 12'hFFF, 12'h000};
  // --------------------------------------------------------------------
  // clocks and instances
  // --------------------------------------------------------------------
  always #20 clk_i = ~clk_i;
  // odd offset keeps sample edges away from system clock edges
  initial begin
    #7;
    forever begin
      #160;
      if (sclk_en) sample_clk_i = ~sample_clk_i;
    end
  end
  dual_adc_output_control #(.LAT(LAT)) dut (
    .clk_i                        (clk_i),
    .nrst_i                       (nrst_i),
    .sample_clk_i                 (sample_clk_i),
    .conv_a_i                     (conv_a_i),
    .conv_b_i                     (conv_b_i),
    .power_down_pin_i             (pd_pin),
    .output_enable_low_pin_i      (oe_pin),
    .serial_clock_format_pin_i    (fmt_pin),
    .serial_data_stabilizer_pin_i (stab_pin),
    .serial_select_low_i          (sel_pin),
    .reg_addr_i                   (reg_addr_i),
    .reg_wdata_i                  (reg_wdata_i),
    .reg_wr_i                     (reg_wr_i),
    .reg_rd_i                     (reg_rd_i),
    .reg_rdata_o                  (reg_rdata_o),
    .chan_a_o                     (chan_a_o),
    .chan_b_o                     (chan_b_o),
    .powered_down_o               (powered_down_o),
    .reference_on_o               (reference_on_o),
    .stabilizer_en_o              (stabilizer_en_o)
  );
  capture_model cap_a (
    .bus_i (chan_a_o),
    .cap_o (cap)
  );
  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask
  task automatic drv(input int a, input int b);
    @(posedge clk_i);
    conv_a_i <= 14'(a);
    conv_b_i <= 14'(b);
  endtask
  task automatic smp(input int n);
    repeat (n) @(posedge sample_clk_i);
    @(negedge sample_clk_i);
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [12:0] enc(input int v, input logic [1:0] f);
    logic [11:0] ob;
    ob = (v > 2047) ? 12'hFFF : (v < -2048) ? 12'h000 : 12'(v + 2048);
    if (f == 2'h1) ob[11] = ~ob[11];
    if (f == 2'h2) ob = ob ^ (ob >> 1);
    return {(v > 2047) || (v < -2048), ob};
  endfunction
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clks(60000);
    error_cnt++;
    stop_test();
  end
  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    clks(3);
    nrst_i <= 1'b1;
    rd(REG_CHAN_IDX, rv);
    `CHK("idx_rst", 8'h03, rv)
    rd(REG_OUT_MODE, rv);
    `CHK("mode_rst", 8'h00, rv)
    rd(10'h3FF, rv);
    `CHK("unmapped", 8'h00, rv)
    drv(100, 0);
    smp(LAT + 2);
    drv(-100, 0);
    smp(LAT);
    `CHK("lat_old", enc(100, 2'h0), {chan_a_o.ovr, chan_a_o.data})
    smp(1);
    `CHK("lat_new", enc(-100, 2'h0), {chan_a_o.ovr, chan_a_o.data})
    for (int f = 0; f < 3; f++) begin
      wr(REG_OUT_MODE, 8'(f));
      foreach (vals[i]) begin
        drv(vals[i], -vals[i]);
        smp(LAT + 2);
        `CHK("fmt_a", enc(vals[i], 2'(f)), {chan_a_o.ovr, chan_a_o.data})
        `CHK("fmt_b", enc(-vals[i], 2'(f)), {chan_b_o.ovr, chan_b_o.data})
        `CHK("cap_a", enc(vals[i], 2'(f)) & 13'h0FFF, {1'b0, cap})
      end
    end
    wr(REG_OUT_MODE, 8'h20);
    drv(5, -7);
    smp(LAT + 2);
    `CHK("il_a", enc(5, 2'h0), {chan_a_o.ovr, chan_a_o.data})
    @(posedge sample_clk_i);
    `CHK("il_b", enc(-7, 2'h0), {chan_a_o.ovr, chan_a_o.data})
    wr(REG_PHASE, 8'h80);
    smp(1);
    `CHK("dco_inv", 2'b11, {chan_a_o.data_clock_output, chan_b_o.data_clock_output})
    wr(REG_PHASE, 8'h00);
    wr(REG_OUT_MODE, 8'h80);
    smp(1);
    `CHK("lvds_dco", 2'b11, {chan_a_o.data_clock_output, chan_b_o.data_clock_output})
    wr(REG_OUT_MODE, 8'h00);
    wr(REG_CHAN_IDX, 8'h02);
    wr(REG_OUT_MODE, 8'h10);
    clks(3);
    `CHK("dis_b", 2'b00, {chan_b_o.data_oe, chan_b_o.dco_oe})
    `CHK("dis_a", 2'b11, {chan_a_o.data_oe, chan_a_o.dco_oe})
    rd(REG_OUT_MODE, rv);
    `CHK("dis_rd", 8'h10, rv)
    wr(REG_OUT_MODE, 8'h00);
    wr(REG_CHAN_IDX, 8'h03);
    oe_pin <= 1'b1;
    clks(5);
    `CHK("oe_off", 1'b1, chan_a_o.data_oe)
    wr(REG_OUT_CTRL, 8'h80);
    clks(5);
    `CHK("oe_hiz", 4'h0, {chan_a_o.data_oe, chan_a_o.dco_oe, chan_b_o.data_oe, chan_b_o.dco_oe})
    oe_pin <= 1'b0;
    clks(5);
    `CHK("oe_on", 2'b11, {chan_a_o.data_oe, chan_a_o.dco_oe})
    wr(REG_OUT_CTRL, 8'h00);
    pd_pin <= 1'b1;
    clks(5);
    `CHK("pd_pin", 4'h8, {powered_down_o, chan_a_o.data_oe, chan_a_o.dco_oe, chan_b_o.data_oe})
    pd_pin <= 1'b0;
    clks(5);
    `CHK("pd_exit", 3'b011, {powered_down_o, chan_a_o.data_oe, chan_a_o.dco_oe})
    for (int p = 0; p < 3; p++) begin
      wr(REG_POWER, 8'(2 - p));
      clks(3);
      `CHK("pmode", (p == 0) ? 2'b11 : (p == 1) ? 2'b10 : 2'b01, {powered_down_o, reference_on_o})
    end
    for (int t = 0; t < 3; t++) begin
      wr(REG_TEST, 8'(t + 1));
      smp(LAT + 2);
      `CHK("tmode", tmx[t], chan_a_o.data)
    end
    // checkerboard and toggle flip every bit from one sample to the next
    for (int t = 0; t < 2; t++) begin
      wr(REG_TEST, (t == 0) ? 8'h04 : 8'h07);
      smp(LAT + 2);
      d = chan_a_o.data;
      smp(1);
      `CHK("tm_alt", 12'hFFF, d ^ chan_a_o.data)
    end
    wr(REG_TEST, 8'h15);
    smp(LAT + 2);
    `CHK("pn_seed", PN_SEED[11:0], chan_a_o.data)
    smp(3);
    `CHK("pn_held", PN_SEED[11:0], chan_a_o.data)
    wr(REG_TEST, 8'h05);
    smp(3);
    // sample clock stands still: nothing may advance
    sclk_en = 1'b0;
    d = chan_a_o.data;
    clks(40);
    `CHK("frozen", d, chan_a_o.data)
    sclk_en = 1'b1;
    wr(REG_TEST, 8'h00);
    nrst_i <= 1'b0;
    sel_pin <= 1'b1;
    fmt_pin <= 1'b1;
    stab_pin <= 1'b1;
    clks(3);
    nrst_i <= 1'b1;
    clks(6);
    `CHK("strap_stab", 1'b1, stabilizer_en_o)
    rd(REG_STATUS, rv);
    `CHK("strap_stat", 8'h1E, rv)
    wr(REG_OUT_MODE, 8'h20);
    rd(REG_OUT_MODE, rv);
    `CHK("strap_wr", 8'h00, rv)
    drv(5, 0);
    smp(LAT + 2);
    `CHK("strap_fmt", enc(5, 2'h1), {chan_a_o.ovr, chan_a_o.data})
    stop_test();
  end
endmodule
`default_nettype wire
